// ===== design/srsc_pkg.sv
// Purpose: shared constants and types of the starter run state control
// Assumes: one clock domain, synchronous active-high reset
// Notes:   register offsets are byte addresses on the plain register port
package srsc_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // control source, profile, frame size
  localparam logic [7:0] ADDR_CMD    = 8'h04;  // cyclic output byte from the network
  localparam logic [7:0] ADDR_STATE  = 8'h08;  // cyclic input byte: state report
  localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;  // sticky event status, write one to clear
  localparam logic [7:0] ADDR_IRQ_MK = 8'h10;  // interrupt mask

  // control register fields
  localparam int CTRL_SRC_BIT  = 0;   // control_source_select
  localparam int CTRL_PROF_LSB = 4;   // profile number, 4 bits
  localparam int CTRL_SIZE_LSB = 8;   // frame size, 3 bits (1..4)
  localparam int CTRL_ORF_BIT  = 12;  // overload relay function allowed

  // cyclic output byte fields
  localparam int CMD_RUN_BIT  = 0;    // run request / start-stop bit
  localparam int CMD_OPEN_BIT = 1;    // operation enable bit from the host
  localparam int CMD_HOST_BIT = 2;    // host control bit (long profiles)

  // reset values
  localparam logic        SRC_RST  = 1'h0;   // local terminals after reset
  localparam logic [3:0]  PROF_RST = 4'hB;   // long profile by default
  localparam logic [2:0]  SIZE_RST = 3'h1;   // smallest frame size
  localparam logic        ORF_RST  = 1'h1;   // overload function allowed
  localparam logic [7:0]  CMD_RST  = 8'h00;  // no request from the network

  // selector positions on the three-position switch
  localparam logic [1:0] SEL_AUTO = 2'h1;
  localparam logic [1:0] SEL_OFF  = 2'h2;
  localparam logic [1:0] SEL_ON   = 2'h3;

  // profile groups
  typedef enum logic [1:0] {
    SRSC_GRP_CONTACTOR = 2'h0,
    SRSC_GRP_SHORT     = 2'h1,
    SRSC_GRP_LONG      = 2'h2,
    SRSC_GRP_NONE      = 2'h3
  } srsc_grp_type;

  // state machine, one-hot
  typedef enum logic [3:0] {
    SRSC_ST_INHIBIT = 4'h1,  // switching on inhibited
    SRSC_ST_READY   = 4'h2,  // ready_state
    SRSC_ST_OPSTOP  = 4'h4,  // operation_state, motor stopped
    SRSC_ST_OPRUN   = 4'h8   // operation_state, motor running
  } srsc_state_type;

  // interrupt event bits
  localparam int EV_ENTER_OP = 0;
  localparam int EV_RUN      = 1;
  localparam int EV_STOP     = 2;
  localparam int EV_OVERLOAD = 3;
  localparam int EV_W        = 4;

endpackage

// ===== design/srsc_cmd_if.sv
// Purpose: condensed command levels passed from the source selector to the state machine
// Assumes: single clock domain
// Notes:   all members are levels from flip-flops or logic of the same clock
`timescale 1ns/1ps
interface srsc_cmd_if;
  logic run_req;     // run request bit as seen by the state machine
  logic op_enable;   // operation enable bit after overload forcing
  logic auto_enter;  // ready to operation passes without an enable
  logic allowed;     // host control condition met (long profiles)

  modport src (output run_req, output op_enable, output auto_enter, output allowed);
  modport fsm (input run_req, input op_enable, input auto_enter, input allowed);
endinterface

// ===== design/srsc_src_sel.sv
// Purpose: chooses local terminals or network byte as command source
// Assumes: terminal inputs already synchronised
// Notes:   overload forcing of the enable applies to every profile
`timescale 1ns/1ps
module srsc_src_sel (
  // configuration
  input  wire logic       net_sel_i,
  input  wire logic [3:0] profile_i,
  input  wire logic [2:0] frame_size_i,
  // local terminals
  input  wire logic       start_term_i,
  input  wire logic       enable_term_i,
  // network byte and protection
  input  wire logic [7:0] cmd_byte_i,
  input  wire logic       overload_force_i,
  // condensed command
  srsc_cmd_if.src         cmd
);

  srsc_pkg::srsc_grp_type grp;  // profile group
  logic                   small_frame;  // frames without enable terminal

  // map profile number to group
  always_comb begin
    unique case (profile_i)
      4'h1, 4'h2, 4'h3:        grp = srsc_pkg::SRSC_GRP_CONTACTOR;
      4'h4, 4'h5, 4'h6, 4'hA:  grp = srsc_pkg::SRSC_GRP_SHORT;
      4'h7, 4'h8, 4'h9, 4'hB:  grp = srsc_pkg::SRSC_GRP_LONG;
      default:                 grp = srsc_pkg::SRSC_GRP_NONE;
    endcase
  end

  assign small_frame = (frame_size_i <= 3'h2);

  // source selection
  always_comb begin
    cmd.allowed = 1'b1;
    if (!net_sel_i) begin
      cmd.run_req    = start_term_i;
      cmd.auto_enter = small_frame;
      cmd.op_enable  = small_frame ? 1'b1 : enable_term_i;
    end else begin
      cmd.run_req = cmd_byte_i[srsc_pkg::CMD_RUN_BIT];
      unique case (grp)
        srsc_pkg::SRSC_GRP_CONTACTOR: begin
          cmd.auto_enter = 1'b1;
          cmd.op_enable  = 1'b1;
        end
        srsc_pkg::SRSC_GRP_LONG: begin
          cmd.auto_enter = 1'b0;
          cmd.op_enable  = cmd_byte_i[srsc_pkg::CMD_OPEN_BIT];
          cmd.allowed    = cmd_byte_i[srsc_pkg::CMD_HOST_BIT];
        end
        srsc_pkg::SRSC_GRP_SHORT: begin
          cmd.auto_enter = 1'b0;
          cmd.op_enable  = cmd_byte_i[srsc_pkg::CMD_OPEN_BIT];
        end
        default: begin
          // unknown profile: hold the unit out of operation
          cmd.auto_enter = 1'b0;
          cmd.op_enable  = 1'b0;
          cmd.allowed    = 1'b0;
        end
      endcase
    end
    if (overload_force_i) begin
      cmd.op_enable  = 1'b0;
      cmd.auto_enter = 1'b0;
    end
  end

endmodule

// ===== design/srsc_fsm.sv
// Purpose: start-up and run state machine of the starter
// Assumes: condensed command arrives as levels on srsc_cmd_if
// Notes:   transitions are checked in priority order, highest first
`timescale 1ns/1ps
module srsc_fsm (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // command
  srsc_cmd_if.fsm   cmd,
  // state
  output srsc_pkg::srsc_state_type state_o,
  output logic      run_edge_o,
  output logic      stop_edge_o,
  output logic      enter_op_o
);

  srsc_pkg::srsc_state_type state_q, state_d;
  logic run_prev_q;  // last run request, to see level changes

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) run_prev_q <= 1'b0;
    else        run_prev_q <= cmd.run_req;
  end

  // priority: leaving operation > entering operation > run change
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      srsc_pkg::SRSC_ST_INHIBIT: begin
        // a stale run request must drop before the unit readies
        if (cmd.allowed && !cmd.run_req) state_d = srsc_pkg::SRSC_ST_READY;
      end
      srsc_pkg::SRSC_ST_READY: begin
        if (!cmd.allowed) state_d = srsc_pkg::SRSC_ST_INHIBIT;
        else if (cmd.auto_enter || cmd.op_enable) state_d = srsc_pkg::SRSC_ST_OPSTOP;
      end
      srsc_pkg::SRSC_ST_OPSTOP: begin
        if (!cmd.allowed) state_d = srsc_pkg::SRSC_ST_INHIBIT;
        else if (!cmd.op_enable && !cmd.auto_enter) state_d = srsc_pkg::SRSC_ST_READY;
        else if (cmd.run_req && !run_prev_q) state_d = srsc_pkg::SRSC_ST_OPRUN;
      end
      srsc_pkg::SRSC_ST_OPRUN: begin
        if (!cmd.allowed) state_d = srsc_pkg::SRSC_ST_INHIBIT;
        else if (!cmd.op_enable && !cmd.auto_enter) state_d = srsc_pkg::SRSC_ST_READY;
        else if (!cmd.run_req && run_prev_q) state_d = srsc_pkg::SRSC_ST_OPSTOP;
      end
      default: state_d = srsc_pkg::SRSC_ST_INHIBIT;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) state_q <= srsc_pkg::SRSC_ST_INHIBIT;
    else        state_q <= state_d;
  end

  assign state_o     = state_q;
  assign run_edge_o  = (state_d == srsc_pkg::SRSC_ST_OPRUN) && (state_q != srsc_pkg::SRSC_ST_OPRUN);
  assign stop_edge_o = (state_q == srsc_pkg::SRSC_ST_OPRUN) && (state_d != srsc_pkg::SRSC_ST_OPRUN);
  assign enter_op_o  = (state_q == srsc_pkg::SRSC_ST_READY) && (state_d == srsc_pkg::SRSC_ST_OPSTOP);

endmodule

// ===== design/srsc_top.sv
// Purpose: starter run state control, register port and protection
// Assumes: 125 MHz clk_sys_i, pins synchronised here
// Notes:   pins pass a two-flop synchroniser before any logic reads them
// Function
// - source select 0 uses local terminals
// - source select 1 uses network profile
// - start terminal level is run request
// - small frames enter operation automatically
// - large frames: enable terminal is enable
// - large frames enter operation on enable
// - overload forces operation enable low
// - local run changes follow start terminal
// - contactor profiles auto enter, start/stop bit
// - short profiles follow run request changes
// - long profiles follow control word bits
// - highest priority transition wins
// - state reported, conditions from output byte
// - overload function only in automatic position
`timescale 1ns/1ps
module srsc_top (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // pins
  input  wire logic        start_term_i,
  input  wire logic        enable_term_i,
  input  wire logic [1:0]  selector_pos_i,
  input  wire logic        overload_i,
  // outputs
  output logic             motor_run_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by the second
  logic [4:0] sync1_q, sync2_q;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {overload_i, selector_pos_i, enable_term_i, start_term_i};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic        src_q;       // control_source_select
  logic [3:0]  prof_q;
  logic [2:0]  size_q;
  logic        orf_en_q;    // overload relay function allowed by software
  logic [7:0]  cmd_q;       // cyclic output byte
  logic [srsc_pkg::EV_W-1:0] ist_q, imk_q, ev;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      src_q    <= srsc_pkg::SRC_RST;
      prof_q   <= srsc_pkg::PROF_RST;
      size_q   <= srsc_pkg::SIZE_RST;
      orf_en_q <= srsc_pkg::ORF_RST;
      cmd_q    <= srsc_pkg::CMD_RST;
      imk_q    <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == srsc_pkg::ADDR_CTRL) begin
        src_q    <= reg_wdata_i[srsc_pkg::CTRL_SRC_BIT];
        prof_q   <= reg_wdata_i[srsc_pkg::CTRL_PROF_LSB +: 4];
        size_q   <= reg_wdata_i[srsc_pkg::CTRL_SIZE_LSB +: 3];
        orf_en_q <= reg_wdata_i[srsc_pkg::CTRL_ORF_BIT];
      end
      if (reg_addr_i == srsc_pkg::ADDR_CMD)    cmd_q <= reg_wdata_i[7:0];
      if (reg_addr_i == srsc_pkg::ADDR_IRQ_MK) imk_q <= reg_wdata_i[srsc_pkg::EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overload relay function: active only in automatic position
  logic orf_active, ovl_force, ovl_prev_q;
  assign orf_active = orf_en_q && (sync2_q[3:2] == srsc_pkg::SEL_AUTO);
  assign ovl_force  = orf_active && sync2_q[4];
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) ovl_prev_q <= 1'b0;
    else        ovl_prev_q <= ovl_force;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command source and state machine
  srsc_cmd_if cmd_bus ();
  srsc_pkg::srsc_state_type st;
  logic run_e, stop_e, enter_e;

  srsc_src_sel srsc_src_sel_i (
    .net_sel_i        (src_q),
    .profile_i        (prof_q),
    .frame_size_i     (size_q),
    .start_term_i     (sync2_q[0]),
    .enable_term_i    (sync2_q[1]),
    .cmd_byte_i       (cmd_q),
    .overload_force_i (ovl_force),
    .cmd              (cmd_bus.src)
  );

  srsc_fsm srsc_fsm_i (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .cmd         (cmd_bus.fsm),
    .state_o     (st),
    .run_edge_o  (run_e),
    .stop_edge_o (stop_e),
    .enter_op_o  (enter_e)
  );

  ////////////////////////////////////////////////////////////////////////////
  // selector positions on and off override the state machine output
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) motor_run_o <= 1'b0;
    else if (sync2_q[3:2] == srsc_pkg::SEL_ON)  motor_run_o <= 1'b1;
    else if (sync2_q[3:2] == srsc_pkg::SEL_OFF) motor_run_o <= 1'b0;
    else motor_run_o <= (st == srsc_pkg::SRSC_ST_OPRUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events: set wins over a write-one clear
  assign ev = {ovl_force && !ovl_prev_q, stop_e, run_e, enter_e};
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) ist_q <= '0;
    else if (reg_wr_i && reg_addr_i == srsc_pkg::ADDR_IRQ_ST)
      ist_q <= (ist_q & ~reg_wdata_i[srsc_pkg::EV_W-1:0]) | ev;
    else ist_q <= ist_q | ev;
  end
  assign irq_o = |(ist_q & imk_q);

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; state byte reported to the host
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i) begin
      unique case (reg_addr_i)
        srsc_pkg::ADDR_CTRL:   reg_rdata_o <= {19'h0, orf_en_q, 1'b0, size_q, prof_q,
                                               3'h0, src_q};
        srsc_pkg::ADDR_CMD:    reg_rdata_o <= {24'h0, cmd_q};
        srsc_pkg::ADDR_STATE:  reg_rdata_o <= {20'h0, 3'h0, orf_active, 2'h0,
                                               sync2_q[3:2], st};
        srsc_pkg::ADDR_IRQ_ST: reg_rdata_o <= {28'h0, ist_q};
        srsc_pkg::ADDR_IRQ_MK: reg_rdata_o <= {28'h0, imk_q};
        default:               reg_rdata_o <= 32'h0000_0000;
      endcase
    end else reg_rdata_o <= 32'h0000_0000;
  end

endmodule

// ===== testbench/srsc_top_checker.sv
// Purpose: port-level assertions for the starter run state control
// Assumes: one clock, srst_i synchronous active high
// Notes:   pin effects get a settle margin for the two-flop synchroniser
`timescale 1ns/1ps
module srsc_top_checker (
  // watched ports
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [1:0]  selector_pos_i,
  input wire logic        overload_i,
  input wire logic        motor_run_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // software copy of the overload function enable, so a disabled function is not flagged
  logic orf_sw_q;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) orf_sw_q <= srsc_pkg::ORF_RST;
    else if (reg_wr_i && reg_addr_i == srsc_pkg::ADDR_CTRL)
      orf_sw_q <= reg_wdata_i[srsc_pkg::CTRL_ORF_BIT];
  end
  ////////////////////////////////////////////////////////////////////////////////
  // read data may only stand in the answer cycle
  chk_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside the answer cycle");
  chk_unmapped_reads_zero: assert property (
    reg_rd_i && reg_addr_i == 8'h14 |=> reg_rdata_o == 32'h0)
    else $error("unmapped read returned data");
  // state report is one-hot
  chk_state_one_hot: assert property (
    reg_rd_i && reg_addr_i == srsc_pkg::ADDR_STATE |=> $onehot(reg_rdata_o[3:0]))
    else $error("state report not one-hot");
  // selector position reported once it has been steady through the sync
  chk_selector_report: assert property (
    $stable(selector_pos_i) [*5] ##0 (reg_rd_i && reg_addr_i == srsc_pkg::ADDR_STATE)
    |=> reg_rdata_o[5:4] == $past(selector_pos_i))
    else $error("selector field wrong");
  // manual positions override the motor output
  chk_off_forces_stop: assert property (
    (selector_pos_i == srsc_pkg::SEL_OFF) [*5] |-> !motor_run_o)
    else $error("motor runs in off position");
  chk_on_forces_run: assert property (
    (selector_pos_i == srsc_pkg::SEL_ON) [*5] |-> motor_run_o)
    else $error("motor stopped in on position");
  // overload in automatic position removes the enable and stops the motor
  chk_overload_stops: assert property (
    (orf_sw_q && selector_pos_i == srsc_pkg::SEL_AUTO && overload_i) [*6] |-> !motor_run_o)
    else $error("motor runs under overload");
  // a cleared mask silences the interrupt on the next cycle
  chk_mask_clears_irq: assert property (
    reg_wr_i && reg_addr_i == srsc_pkg::ADDR_IRQ_MK && reg_wdata_i == 32'h0 |=> !irq_o)
    else $error("irq high with empty mask");
endmodule

bind srsc_top srsc_top_checker srsc_top_checker_i (.clk_sys_i, .srst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .selector_pos_i, .overload_i,
  .motor_run_o, .irq_o);

// ===== testbench/srsc_plc_model.sv
// Purpose: gateway and host controller model writing the cyclic output byte
// Assumes: slave never stalls, read data in the cycle after the strobe
// Notes:   released write data is inverted so a stale value never looks valid
`timescale 1ns/1ps
module srsc_plc_model (
  // clock
  input  wire logic        clk_sys_i,
  // register port, master side
  output logic      [7:0]  reg_addr_o,
  output logic      [31:0] reg_wdata_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  input  wire logic [31:0] reg_rdata_i
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 32'h0;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one write cycle, changed just after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  // one read cycle; data taken in the answer cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o   <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask
  // cyclic output byte; long profiles carry the host control bit beside each condition
  task automatic send_cmd(input logic [7:0] b, input logic host);
    wr(srsc_pkg::ADDR_CMD, {24'h0, b | {5'h0, host, 2'h0}});
  endtask
endmodule

// ===== testbench/srsc_top_tb.sv
// Purpose: self-checking bench of the starter run state control
// Assumes: 125 MHz clock, overload function bit kept set in every control word
// Notes:   each profile case starts from a fresh reset so cases stay independent
`timescale 1ns/1ps
module srsc_top_tb;
  logic        clk_sys_i = 1'b0;       // system clock
  logic        srst_i = 1'b1;          // synchronous reset
  logic        start_term_i = 1'b0;    // start terminal level
  logic        enable_term_i = 1'b0;   // enable terminal level
  logic [1:0]  selector_pos_i = srsc_pkg::SEL_AUTO; // three-position switch
  logic        overload_i = 1'b0;      // overload present
  logic [7:0]  reg_addr_i;             // register port from the host model
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic        motor_run_o;
  logic        irq_o;
  int          bad_count = 0;
  int          samples_checked = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  srsc_top srsc_top_i (.clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .start_term_i, .enable_term_i, .selector_pos_i, .overload_i, .motor_run_o,
    .irq_o);
  srsc_plc_model plc_i (.clk_sys_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // covers sync, state and motor latency with margin
  task automatic settle();
    repeat (6) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic pins(input logic s, input logic e, input logic [1:0] sel, input logic ov);
    @(posedge clk_sys_i);
    start_term_i   <= s;
    enable_term_i  <= e;
    selector_pos_i <= sel;
    overload_i     <= ov;
    settle();
  endtask
  // mid-run reset, then the control word
  task automatic restart(input logic [31:0] ctrl);
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    chk("motor after reset", motor_run_o, 32'h0);
    chk("irq after reset", irq_o, 32'h0);
    plc_i.wr(srsc_pkg::ADDR_CTRL, ctrl);
    settle();
  endtask
  task automatic state_is(input string name, input logic [3:0] exp);
    logic [31:0] d;
    plc_i.rd(srsc_pkg::ADDR_STATE, d);
    chk(name, d[3:0], exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // local, small frame: automatic entry, start terminal runs, network ignored
  task automatic t_local_small();
    pins(1'b0, 1'b0, srsc_pkg::SEL_AUTO, 1'b0);
    restart(32'h0000_11B0);
    state_is("small auto entry", srsc_pkg::SRSC_ST_OPSTOP);
    plc_i.send_cmd(8'h03, 1'b1);
    settle();
    chk("net ignored in local", motor_run_o, 32'h0);
    pins(1'b1, 1'b0, srsc_pkg::SEL_AUTO, 1'b0);
    chk("start terminal runs", motor_run_o, 32'h1);
    state_is("running state", srsc_pkg::SRSC_ST_OPRUN);
    pins(1'b0, 1'b0, srsc_pkg::SEL_AUTO, 1'b0);
    chk("start terminal stops", motor_run_o, 32'h0);
  endtask
  // local, large frame: enable terminal, overload, selector, interrupts
  task automatic t_local_large();
    logic [31:0] d;
    pins(1'b0, 1'b0, srsc_pkg::SEL_AUTO, 1'b0);
    restart(32'h0000_13B0);
    state_is("large waits enable", srsc_pkg::SRSC_ST_READY);
    pins(1'b0, 1'b1, srsc_pkg::SEL_AUTO, 1'b0);
    state_is("enable enters op", srsc_pkg::SRSC_ST_OPSTOP);
    pins(1'b1, 1'b1, srsc_pkg::SEL_AUTO, 1'b0);
    chk("large runs", motor_run_o, 32'h1);
    pins(1'b1, 1'b1, srsc_pkg::SEL_AUTO, 1'b1);
    chk("overload stops", motor_run_o, 32'h0);
    plc_i.rd(srsc_pkg::ADDR_STATE, d);
    chk("overload drops state", d[3:0], srsc_pkg::SRSC_ST_READY);
    chk("overload fn in auto", d[8], 32'h1);
    plc_i.rd(srsc_pkg::ADDR_IRQ_ST, d);
    chk("overload event", d[srsc_pkg::EV_OVERLOAD], 32'h1);
    plc_i.wr(srsc_pkg::ADDR_IRQ_MK, 32'h0000_000F);
    plc_i.rd(srsc_pkg::ADDR_IRQ_MK, d);
    chk("mask readback", d, 32'h0000_000F);
    chk("unmasked irq", irq_o, 32'h1);
    plc_i.wr(srsc_pkg::ADDR_IRQ_MK, 32'h0);
    #1;
    chk("masked irq", irq_o, 32'h0);
    plc_i.wr(srsc_pkg::ADDR_IRQ_MK, 32'h0000_000F);
    pins(1'b1, 1'b1, srsc_pkg::SEL_OFF, 1'b1);
    plc_i.rd(srsc_pkg::ADDR_STATE, d);
    chk("overload fn off pos", d[8], 32'h0);
    pins(1'b1, 1'b1, srsc_pkg::SEL_ON, 1'b1);
    chk("on position runs", motor_run_o, 32'h1);
    plc_i.wr(srsc_pkg::ADDR_IRQ_ST, 32'h0000_000F);
    settle();
    chk("cleared irq", irq_o, 32'h0);
    plc_i.wr(8'h14, 32'hFFFF_FFFF);
    plc_i.rd(8'h14, d);
    chk("unmapped read", d, 32'h0);
  endtask
  // network control, every profile; terminals held active and must be ignored
  task automatic t_net();
    logic [31:0] d;
    logic        lg;
    for (int p = 1; p <= 11; p++) begin
      lg = (p inside {7, 8, 9, 11});
      pins(1'b1, 1'b1, srsc_pkg::SEL_AUTO, 1'b0);
      restart(32'h0000_1101 | (32'(p) << 4));
      plc_i.send_cmd(8'h02, 1'b0);
      settle();
      plc_i.rd(srsc_pkg::ADDR_STATE, d);
      chk("entry without host bit", d[2], {31'h0, !lg});
      plc_i.send_cmd(8'h02, lg);
      settle();
      state_is("net entry", srsc_pkg::SRSC_ST_OPSTOP);
      plc_i.send_cmd(8'h03, lg);
      settle();
      chk("net run", motor_run_o, 32'h1);
      plc_i.send_cmd(8'h02, lg);
      settle();
      chk("net stop", motor_run_o, 32'h0);
    end
    // a profile number outside the table keeps the unit out of operation
    restart(32'h0000_11C1);
    plc_i.send_cmd(8'h02, 1'b1);
    settle();
    state_is("unknown profile held", srsc_pkg::SRSC_ST_INHIBIT);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_local_small();
    t_local_large();
    t_net();
    close_out();
  end
  // watchdog well beyond the expected run of about 750 cycles
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule
